/* File: accrd_pkg.sv */
// Package of constants for the accumulator readout register block
// How it works
// RQ1 - Host reads a 24-bit count of accumulations since the last snapshot.
// RQ2 - A snapshot copies the running count into the readable count register.
// RQ3 - Host divides each channel total by the count to get averages.
// RQ4 - Running count holds at its maximum instead of wrapping to zero.
// RQ5 - Channel one total holds power or current, chosen by control bit 7.
// RQ6 - Channel two total holds power or current, chosen by control bit 7.
// RQ7 - Channel one readable total is 56 bits wide and read only.
// RQ8 - A snapshot moves running totals into the readable result registers.
// RQ9 - Running totals saturate at their 56-bit maximum instead of wrapping.
// RQ10 - Totals are unsigned binary integers.
// RQ11 - Mode zero sums 16-bit current values, mode one sums power values.
// RQ12 - Any overflow sets the saturation flag and halts accumulation.
// RQ13 - Snapshot clears and restarts; flag stays until host writes zero.
// RQ14 - Count and both totals are captured together in one cycle.
// RQ15 - Readable count and totals reset to zero and ignore host writes.
package accrd_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCRD_CTRL_ADDR = 8'h01;
  localparam logic [7:0] ACCRD_CNT_ADDR = 8'h02;
  localparam logic [7:0] ACCRD_CH1_ADDR = 8'h03;
  localparam logic [7:0] ACCRD_CH2_ADDR = 8'h04;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ACCRD_MODE_BIT = 7;
  localparam int ACCRD_FLAG_BIT = 0;
  localparam int ACCRD_CNT_W = 24;
  localparam int ACCRD_ACC_W = 56;
  localparam int ACCRD_CUR_W = 16;
  localparam int ACCRD_PWR_W = 30;
  localparam int ACCRD_RD_W = 64;
  localparam logic [63:0] ACCRD_ZERO = 64'h0;
  typedef enum logic {ACCRD_RUN, ACCRD_IDLE} accrd_state_t;
endpackage : accrd_pkg

/* File: accrd_sat_acc.sv */
// Saturating unsigned accumulator with synchronous clear
`timescale 1ns/1ps
module accrd_sat_acc #(
  parameter int W = 56,
  parameter int IW = 30
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic add_in,
  input wire logic [IW-1:0] value_in,
  output logic [W-1:0] total_out,
  output logic at_max_out
);
  initial begin
    if (IW >= W) $error("accrd_sat_acc: input wider than total");
  end
  logic [W-1:0] total_q;
  logic [W-1:0] total_d;
  logic [W:0] sum;
  // ----------------------------------------------------------------
  // Next total; unsigned add, held at all ones on carry out
  // ----------------------------------------------------------------
  always_comb begin
    sum = {1'b0, total_q} + {{(W+1-IW){1'b0}}, value_in}; // RQ10
    total_d = total_q;
    if (clear_in) begin
      total_d = '0;
    end else if (add_in) begin
      total_d = sum[W] ? '1 : sum[W-1:0]; // RQ9
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      total_q <= '0;
    end else begin
      total_q <= total_d;
    end
  end
  assign total_out = total_q;
  assign at_max_out = &total_q;
endmodule : accrd_sat_acc

/* File: accrd_sat_cnt.sv */
// Saturating up counter with synchronous clear
`timescale 1ns/1ps
module accrd_sat_cnt #(
  parameter int W = 24
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic step_in,
  output logic [W-1:0] count_out,
  output logic at_max_out
);
  initial begin
    if (W < 2) $error("accrd_sat_cnt: width too small");
  end
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  // Next count, held at all ones
  always_comb begin
    count_d = count_q;
    if (clear_in) begin
      count_d = '0;
    end else if (step_in && !(&count_q)) begin
      count_d = count_q + 1'b1; // RQ4
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_out = count_q;
  assign at_max_out = &count_q;
endmodule : accrd_sat_cnt

/* File: accrd_top.sv */
// Accumulator readout registers with snapshot, mode and saturation flag
`timescale 1ns/1ps
module accrd_top
  import accrd_pkg::*;
#(
  parameter int CNT_W = ACCRD_CNT_W,
  parameter int ACC_W = ACCRD_ACC_W
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Sample side: one pulse per accumulation step
  input wire logic sample_valid_in,
  input wire logic [ACCRD_CUR_W-1:0] ch1_current_in,
  input wire logic [ACCRD_CUR_W-1:0] ch2_current_in,
  input wire logic [ACCRD_PWR_W-1:0] ch1_power_in,
  input wire logic [ACCRD_PWR_W-1:0] ch2_power_in,
  // Snapshot command from the serial slave
  input wire logic snapshot_in,
  // Register port from the serial slave
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [ACCRD_RD_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_err_out,
  // Status views
  output logic mode_power_out,
  output logic saturation_flag_out,
  output logic running_out
);
  initial begin
    // Narrower widths are allowed so that saturation can be reached
    // in a short run; a total must stay wider than one power sample.
    if (CNT_W < 2 || CNT_W > ACCRD_CNT_W ||
        ACC_W <= ACCRD_PWR_W || ACC_W > ACCRD_ACC_W) begin
      $error("accrd_top: unsupported count or total width");
    end
  end
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic accrd_hit(input logic [7:0] a,
                                     input logic [7:0] ref_a);
    accrd_hit = (a == ref_a);
  endfunction : accrd_hit
  logic wr_ctrl;
  logic clear_flag;
  assign wr_ctrl = reg_wr_in && accrd_hit(reg_addr_in, ACCRD_CTRL_ADDR);
  // Only a written zero clears the flag; a one is ignored
  assign clear_flag = wr_ctrl && !reg_wdata_in[ACCRD_FLAG_BIT]; // RQ13
  // ----------------------------------------------------------------
  // Control, flag and run state
  // ----------------------------------------------------------------
  logic mode_q;
  logic mode_d;
  logic flag_q;
  logic flag_d;
  accrd_state_t state_q;
  accrd_state_t state_d;
  logic cnt_max;
  logic ch1_max;
  logic ch2_max;
  logic any_max;
  logic step;
  assign any_max = cnt_max || ch1_max || ch2_max;
  // No step is taken once halted, so the totals freeze on overflow.
  // The cycle in which a maximum is reached is gated too; otherwise
  // a back to back sample would reach the totals but not the count.
  assign step = sample_valid_in && (state_q == ACCRD_RUN) && !any_max
    && !snapshot_in; // RQ12 RQ14
  always_comb begin
    mode_d = mode_q;
    flag_d = flag_q;
    state_d = state_q;
    if (wr_ctrl) begin
      mode_d = reg_wdata_in[ACCRD_MODE_BIT]; // RQ5 RQ6
    end
    if (clear_flag) begin
      flag_d = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (any_max && !snapshot_in) begin
      flag_d = 1'b1; // RQ12
    end
    unique case (state_q)
      ACCRD_RUN: begin
        if (any_max && !snapshot_in) begin
          state_d = ACCRD_IDLE; // RQ12
        end
      end
      ACCRD_IDLE: begin
        if (snapshot_in) begin
          state_d = ACCRD_RUN; // RQ13
        end
      end
    endcase
  end
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= 1'b0;
      flag_q <= 1'b0;
      state_q <= ACCRD_RUN;
    end else begin
      mode_q <= mode_d;
      flag_q <= flag_d;
      state_q <= state_d;
    end
  end
  // ----------------------------------------------------------------
  // Running totals and count
  // ----------------------------------------------------------------
  logic [ACCRD_PWR_W-1:0] ch1_val;
  logic [ACCRD_PWR_W-1:0] ch2_val;
  logic [CNT_W-1:0] run_cnt;
  logic [ACC_W-1:0] run_ch1;
  logic [ACC_W-1:0] run_ch2;
  // Mode picks summed quantity; current is zero-extended
  assign ch1_val = mode_q ? ch1_power_in
    : {{(ACCRD_PWR_W-ACCRD_CUR_W){1'b0}}, ch1_current_in}; // RQ11 RQ5
  assign ch2_val = mode_q ? ch2_power_in
    : {{(ACCRD_PWR_W-ACCRD_CUR_W){1'b0}}, ch2_current_in}; // RQ11 RQ6
  accrd_sat_cnt #(.W(CNT_W)) u_cnt (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .clear_in(snapshot_in),
    .step_in(step),
    .count_out(run_cnt),
    .at_max_out(cnt_max)
  );
  accrd_sat_acc #(.W(ACC_W), .IW(ACCRD_PWR_W)) u_ch1 (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .clear_in(snapshot_in),
    .add_in(step),
    .value_in(ch1_val),
    .total_out(run_ch1),
    .at_max_out(ch1_max)
  );
  accrd_sat_acc #(.W(ACC_W), .IW(ACCRD_PWR_W)) u_ch2 (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_q),
    .clear_in(snapshot_in),
    .add_in(step),
    .value_in(ch2_val),
    .total_out(run_ch2),
    .at_max_out(ch2_max)
  );
  // ----------------------------------------------------------------
  // Host-readable snapshot registers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] step_count_q;
  logic [CNT_W-1:0] step_count_d;
  logic [ACC_W-1:0] ch1_total_q;
  logic [ACC_W-1:0] ch1_total_d;
  logic [ACC_W-1:0] ch2_total_q;
  logic [ACC_W-1:0] ch2_total_d;
  // A sample arriving with the snapshot is dropped from both
  // intervals; the step gate keeps the three values consistent.
  always_comb begin
    step_count_d = step_count_q;
    ch1_total_d = ch1_total_q;
    ch2_total_d = ch2_total_q;
    if (snapshot_in) begin
      step_count_d = run_cnt; // RQ2 RQ14 RQ1
      ch1_total_d = run_ch1; // RQ8 RQ14 RQ7
      ch2_total_d = run_ch2; // RQ8 RQ14
    end
  end
  // Host writes never reach these registers
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step_count_q <= '0; // RQ15
      ch1_total_q <= '0; // RQ15
      ch2_total_q <= '0; // RQ15
    end else begin
      step_count_q <= step_count_d;
      ch1_total_q <= ch1_total_d;
      ch2_total_q <= ch2_total_d;
    end
  end
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [ACCRD_RD_W-1:0] rdata_q;
  logic [ACCRD_RD_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic err_q;
  logic err_d;
  // Reads answer one cycle later; unmapped reads give zero and err
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_in;
    err_d = 1'b0;
    if (reg_rd_in) begin
      rdata_d = ACCRD_ZERO;
      if (accrd_hit(reg_addr_in, ACCRD_CTRL_ADDR)) begin
        rdata_d[ACCRD_MODE_BIT] = mode_q;
        rdata_d[ACCRD_FLAG_BIT] = flag_q;
      end else if (accrd_hit(reg_addr_in, ACCRD_CNT_ADDR)) begin
        rdata_d[CNT_W-1:0] = step_count_q; // RQ1
      end else if (accrd_hit(reg_addr_in, ACCRD_CH1_ADDR)) begin
        rdata_d[ACC_W-1:0] = ch1_total_q; // RQ7
      end else if (accrd_hit(reg_addr_in, ACCRD_CH2_ADDR)) begin
        rdata_d[ACC_W-1:0] = ch2_total_q;
      end else begin
        err_d = 1'b1;
      end
    end
    // Writes outside the control byte are flagged as refused
    if (reg_wr_in && !wr_ctrl) begin
      err_d = 1'b1; // RQ15
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= ACCRD_ZERO;
      rvalid_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      err_q <= err_d;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign reg_err_out = err_q;
  assign mode_power_out = mode_q;
  assign saturation_flag_out = flag_q;
  assign running_out = (state_q == ACCRD_RUN);
endmodule : accrd_top

/* File: accrd_top_checker.sv */
// Port checker of the accumulator readout registers
`timescale 1ns/1ps
module accrd_top_checker (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic snapshot_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [63:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic reg_err_out,
  input wire logic mode_power_out,
  input wire logic saturation_flag_out,
  input wire logic running_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // Control write decode, shared by mode and flag checks
  logic wr_ctl;
  assign wr_ctl = reg_wr_in && reg_addr_in == 8'h01;
  property p_rvalid;
    reg_rd_in |=> reg_rvalid_out;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read answer missing");
  property p_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved");
  property p_ro;
    reg_wr_in && !wr_ctl |=> reg_err_out;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only write not refused");
  property p_mode;
    wr_ctl |=> mode_power_out == $past(reg_wdata_in[7]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode bit not taken");
  property p_halt;
    $rose(saturation_flag_out) |-> !running_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("still running on overflow");
  property p_idle;
    !running_out && !snapshot_in |=> !running_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("left idle without snapshot");
  property p_resume;
    snapshot_in |=> running_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("snapshot did not resume");
  property p_keep;
    saturation_flag_out && !(wr_ctl && !reg_wdata_in[0])
      |=> saturation_flag_out;
  endproperty
  a_keep: assert property (p_keep)
    else $error("flag lost without clear");
endmodule : accrd_top_checker

bind accrd_top accrd_top_checker u_chk (.core_clk_in, .rstn_in,
  .snapshot_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
  .reg_rdata_out, .reg_rvalid_out, .reg_err_out, .mode_power_out,
  .saturation_flag_out, .running_out);

/* File: accrd_sampler.sv */
// Sample source standing in for the sampling engine
`timescale 1ns/1ps
module accrd_sampler (
  input wire logic core_clk_in,
  output logic valid_out,
  output logic [15:0] cur1_out,
  output logic [15:0] cur2_out,
  output logic [29:0] pwr1_out,
  output logic [29:0] pwr2_out
);
  initial begin
    valid_out = 1'b0;
    {cur1_out, cur2_out, pwr1_out, pwr2_out} = '0;
  end
  // Steps of one cycle; values flip when idle so stale data never counts
  task automatic burst(input int n, input logic [15:0] c1, c2,
                       input logic [29:0] p1, p2);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk_in);
      valid_out = 1'b1;
      {cur1_out, cur2_out, pwr1_out, pwr2_out} = {c1, c2, p1, p2};
      @(negedge core_clk_in);
      valid_out = 1'b0;
      {cur1_out, cur2_out, pwr1_out, pwr2_out} = ~{c1, c2, p1, p2};
    end
  endtask : burst
endmodule : accrd_sampler

/* File: accrd_top_tb.sv */
// Self-checking testbench of the accumulator readout registers
`timescale 1ns/1ps
module accrd_top_tb;
  import accrd_pkg::*;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic snapshot_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [63:0] reg_rdata_out;
  logic reg_rvalid_out, reg_err_out, mode_power_out;
  logic saturation_flag_out, running_out, sv;
  logic [15:0] c1, c2;
  logic [29:0] p1, p2;
  int n_fail = 0;
  int total_checks = 0;
  // Short count and total widths so saturation is reached quickly
  accrd_sampler smp (.core_clk_in, .valid_out(sv), .cur1_out(c1),
    .cur2_out(c2), .pwr1_out(p1), .pwr2_out(p2));
  accrd_top #(.CNT_W(4), .ACC_W(32)) uut (.core_clk_in, .rstn_in,
    .sample_valid_in(sv), .ch1_current_in(c1), .ch2_current_in(c2),
    .ch1_power_in(p1), .ch2_power_in(p2), .snapshot_in, .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .reg_rvalid_out, .reg_err_out, .mode_power_out,
    .saturation_flag_out, .running_out);
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // One-cycle strobe; answer is sampled on the next falling edge
  task automatic rd_raw(input logic [7:0] a);
    @(negedge core_clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
  endtask : rd_raw
  task automatic rd(input logic [7:0] a, input logic [63:0] exp);
    rd_raw(a);
    chk("rvalid", reg_rvalid_out, 64'h1);
    chk($sformatf("reg %0h", a), reg_rdata_out, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic snap();
    @(negedge core_clk_in);
    snapshot_in = 1'b1;
    @(negedge core_clk_in);
    snapshot_in = 1'b0;
  endtask : snap
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    // Reset values and refused accesses
    rd(ACCRD_CNT_ADDR, 64'h0);
    rd(ACCRD_CH1_ADDR, 64'h0);
    rd(ACCRD_CH2_ADDR, 64'h0);
    wr(ACCRD_CH1_ADDR, 8'hFF);
    chk("wr err", reg_err_out, 64'h1);
    rd(ACCRD_CH1_ADDR, 64'h0);
    rd_raw(8'h7F);
    chk("rd err", reg_err_out, 64'h1);
    $display("test reset done");
    // Current mode; power lines carry junk that must be ignored
    smp.burst(3, 16'h1234, 16'hFFFF, 30'h3FFFFFFF, 30'h3FFFFFFF);
    snap();
    rd(ACCRD_CNT_ADDR, 64'h3);
    rd(ACCRD_CH1_ADDR, 64'h369C);
    rd(ACCRD_CH2_ADDR, 64'h2FFFD);
    snap();
    rd(ACCRD_CNT_ADDR, 64'h0);
    rd(ACCRD_CH1_ADDR, 64'h0);
    $display("test current done");
    // Power mode on both channels
    wr(ACCRD_CTRL_ADDR, 8'h80);
    rd(ACCRD_CTRL_ADDR, 64'h80);
    chk("mode", mode_power_out, 64'h1);
    smp.burst(2, 16'hFFFF, 16'hFFFF, 30'h100, 30'h2);
    snap();
    rd(ACCRD_CH1_ADDR, 64'h200);
    // Host side average over the two steps of this interval
    chk("ch1 average", reg_rdata_out / 64'h2, 64'h100);
    rd(ACCRD_CH2_ADDR, 64'h4);
    $display("test power done");
    // Count saturates at 15; the sixteenth step is not taken
    smp.burst(16, 16'h0, 16'h0, 30'h1, 30'h1);
    chk("running", running_out, 64'h0);
    snap();
    rd(ACCRD_CNT_ADDR, 64'hF);
    rd(ACCRD_CH1_ADDR, 64'hF);
    rd(ACCRD_CTRL_ADDR, 64'h81);
    wr(ACCRD_CTRL_ADDR, 8'h80);
    rd(ACCRD_CTRL_ADDR, 64'h80);
    $display("test count done");
    // Channel one total saturates at all ones of its 32-bit width on
    // the fifth step; channel two and the count stop with it
    smp.burst(5, 16'h0, 16'h0, 30'h3FFFFFFF, 30'h3);
    snap();
    rd(ACCRD_CH1_ADDR, 64'hFFFFFFFF);
    rd(ACCRD_CH2_ADDR, 64'hF);
    rd(ACCRD_CNT_ADDR, 64'h5);
    rd(ACCRD_CTRL_ADDR, 64'h81);
    $display("test total done");
    conclude();
  end
  // Watchdog well beyond the roughly 120 cycles the tests take
  initial begin
    #20us;
    n_fail++;
    conclude();
  end
endmodule : accrd_top_tb
